// ### dv/llc_model.sv
// Purpose: behavioural link-layer controller on the link pins
// Assumes: sense_mode 0 unpowered, 1 steady supply, 2 pulsed via barrier
// Notes: pulse is 30 ns high, 1 us low
`timescale 1ns/1ps
module llc_model
(
    // bench control
    input wire logic [1:0] sense_mode,
    input wire logic want_service,
    // link pins
    output logic link_power_sense,
    output logic link_service_request
);
    initial
    begin
        link_power_sense = 1'b0;
        forever
        begin
            if (sense_mode == 2'h2)
            begin
                link_power_sense = 1'b1;
                #30;
                link_power_sense = 1'b0;
                #1000;
            end
            else
            begin
                link_power_sense = (sense_mode == 2'h1);
                #5;
            end
        end
    end
    assign link_service_request = want_service;
endmodule

// ### dv/test_link_power_status_monitor.sv
// Purpose: self-checking bench for the link power status monitor
// Assumes: aclk 10 ns, link_clk 6 ns, registers over axi4-lite
// Notes: llc_model plays the link-layer controller
`timescale 1ns/1ps
module test_link_power_status_monitor;
    import lpsm_pkg::*;
    logic aclk, aresetn, power_down, link_clk;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, interface_control_lines, core_control, sense_mode;
    logic link_power_sense, interface_mode_select, link_service_request, interface_clock;
    logic [7:0] link_data_out, core_data;
    logic core_service_request, want_service, all_ports_cable_power_disable;
    logic self_id_link_active, power_sense_active;
    port_status_type [NUM_PORTS-1:0] port_status;
    logic [NUM_PORTS-1:0] cable_power_disable;
    int n_mismatch, n_checks, n_pclk;

    link_power_status_monitor dut_u (.aclk(aclk), .aresetn(aresetn), .power_down(power_down),
        .link_clk(link_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link_power_sense(link_power_sense), .interface_mode_select(interface_mode_select),
        .link_service_request(link_service_request),
        .interface_control_lines(interface_control_lines), .link_data_out(link_data_out),
        .interface_clock(interface_clock), .core_control(core_control),
        .core_data(core_data), .core_service_request(core_service_request),
        .port_status(port_status), .cable_power_disable(cable_power_disable),
        .all_ports_cable_power_disable(all_ports_cable_power_disable),
        .self_id_link_active(self_id_link_active), .power_sense_active(power_sense_active));
    llc_model llc_u (.sense_mode(sense_mode), .want_service(want_service),
        .link_power_sense(link_power_sense), .link_service_request(link_service_request));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    always @(posedge interface_clock)
        n_pclk++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ends settled, mid-cycle
    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic count_pclk(output int n);
        n_pclk = 0;
        #600;
        n = n_pclk;
    endtask
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
        output logic [1:0] resp);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok)
        begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_ok)
                awvalid <= 1'b0;
            if (w_ok)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp,
        input logic [1:0] exp_resp);
        logic ar_ok, r_ok;
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok)
        begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            if (r_ok)
            begin
                check(rdata, exp);
                check(rresp, exp_resp);
            end
            @(posedge aclk);
            if (ar_ok)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic t_regs();
        logic [1:0] r;
        rd_check(CONFIG_OFFSET, ZERO_WORD, RESP_OKAY);
        rd_check(STATUS_OFFSET, 32'h0000_0004, RESP_OKAY);
        axi_write(CONFIG_OFFSET, 32'h0000_0001, r);
        check(r, RESP_OKAY);
        rd_check(STATUS_OFFSET, 32'h0000_000C, RESP_OKAY);
        axi_write(STATUS_OFFSET, 32'hFFFF_FFFF, r);
        check(r, RESP_OKAY);
        rd_check(STATUS_OFFSET, 32'h0000_000C, RESP_OKAY);
        wait_clk(1);
        check(self_id_link_active, 1'b1);
        axi_write(8'h10, 32'h0000_0001, r);
        check(r, RESP_SLVERR);
        rd_check(8'h10, ZERO_WORD, RESP_SLVERR);
        @(posedge aclk);
        power_down <= 1'b1;
        wait_clk(4);
        check(self_id_link_active, 1'b0);
        @(posedge aclk);
        power_down <= 1'b0;
        wait_clk(4);
        rd_check(CONFIG_OFFSET, ZERO_WORD, RESP_OKAY);
        $display("register test done");
    endtask
    task automatic t_cable();
        logic [4:0] st [9] = '{5'h10, 5'h08, 5'h04, 5'h06, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02};
        logic [2:0] ct [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h5, 3'h1, 3'h2};
        logic [8:0] ex = 9'b001100111;
        logic [2:0] v;
        logic [1:0] r;
        for (int k = 0; k < 9; k++)
        begin
            @(posedge aclk);
            for (int i = 0; i < 3; i++)
            begin
                port_status[i] <= st[(k + i) % 9];
                v[i] = ex[(k + i) % 9];
            end
            axi_write(PORT_CTRL_OFFSET, {23'h0, ct[(k + 2) % 9], ct[(k + 1) % 9], ct[k]}, r);
            wait_clk(3);
            check(cable_power_disable, v);
            check(all_ports_cable_power_disable, &v);
            rd_check(CABLE_OFFSET, {25'h0, &v, 3'h0, v}, RESP_OKAY);
        end
        $display("cable power test done");
    endtask
    task automatic t_link();
        int n;
        @(posedge link_clk);
        want_service <= 1'b1;
        interface_mode_select <= 1'b1;
        repeat (8) @(posedge link_clk);
        @(negedge link_clk);
        check(link_data_out, 8'hA5);
        check(interface_control_lines, 2'h3);
        check(core_service_request, 1'b1);
        count_pclk(n);
        check(n >= 49 && n <= 51, 1'b1);
        @(posedge link_clk);
        interface_mode_select <= 1'b0;
        repeat (8) @(posedge link_clk);
        count_pclk(n);
        check(n >= 24 && n <= 26, 1'b1);
        $display("link interface test done");
    endtask
    task automatic t_sense();
        int n, lows;
        @(posedge aclk);
        sense_mode <= 2'h2;
        lows = 0;
        repeat (600)
        begin
            @(negedge aclk);
            lows += (power_sense_active !== 1'b1);
        end
        check(lows, 0);
        // stop right after a pulse rises, so the low time starts from a known point
        @(posedge link_power_sense);
        @(posedge aclk);
        sense_mode <= 2'h0;
        n = 0;
        while (power_sense_active === 1'b1 && n < 400)
        begin
            @(negedge aclk);
            n++;
        end
        check(n > 260 && n < 272, 1'b1);
        wait_clk(6);
        check(link_data_out, 8'h00);
        check(interface_control_lines, 2'h0);
        check(core_service_request, 1'b0);
        count_pclk(n);
        check(n > 0, 1'b1);
        rd_check(STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        check(self_id_link_active, 1'b0);
        wait_clk(2200);
        rd_check(STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        wait_clk(100);
        rd_check(STATUS_OFFSET, 32'h0000_0002, RESP_OKAY);
        count_pclk(n);
        check(n, 0);
        @(posedge aclk);
        sense_mode <= 2'h1;
        wait_clk(20);
        check(power_sense_active, 1'b1);
        check(link_data_out, 8'hA5);
        $display("power sense test done");
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        aresetn = 1'b0;
        power_down = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, want_service} = '0;
        wstrb = 4'hF;
        core_control = 2'h3;
        core_data = 8'hA5;
        interface_mode_select = 1'b1;
        sense_mode = 2'h1;
        port_status = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wait_clk(4);
        t_regs();
        t_cable();
        t_link();
        t_sense();
        test_done();
    end
endmodule

// ### rtl/link_power_status_monitor.sv
// Purpose: power-sense monitor, interface gating and cable-power disable
// Assumes: link_clk is twice the fast interface clock rate
// Notes: registers on AXI4-Lite in the aclk domain
`timescale 1ns/1ps
module link_power_status_monitor
    import lpsm_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_down,
    // link clock domain
    input wire logic link_clk,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // link pins
    input wire logic link_power_sense,
    input wire logic interface_mode_select,
    input wire logic link_service_request,
    output logic [1:0] interface_control_lines,
    output logic [7:0] link_data_out,
    output logic interface_clock,
    // core side, link domain
    input wire logic [1:0] core_control,
    input wire logic [7:0] core_data,
    output logic core_service_request,
    // ports and link status
    input wire port_status_type [NUM_PORTS-1:0] port_status,
    output logic [NUM_PORTS-1:0] cable_power_disable,
    output logic all_ports_cable_power_disable,
    output logic self_id_link_active,
    output logic power_sense_active
);
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == CONFIG_OFFSET) || (a == PORT_CTRL_OFFSET) ||
                      (a == STATUS_OFFSET) || (a == CABLE_OFFSET);
    endfunction
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    function automatic logic port_off(input port_status_type s, input port_ctrl_type c);
        port_off = s.disconnected || s.asleep || (s.ds_connected && !s.active) ||
                   (c.disabled && (c.hard_disable || c.sleep_enable));
    endfunction
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic rst_int;
    logic run_a;
    logic [CNT_W-1:0] low_count;
    power_state_type state;
    power_state_type next_state;
    logic hold_low_a;
    logic clk_stop_a;
    logic link_active_ctrl;
    port_ctrl_type [NUM_PORTS-1:0] port_ctrl;
    logic [NUM_PORTS-1:0] next_cable;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] wr_mask;
    logic [31:0] port_word;
    logic [31:0] strb_mask;
    // sense and power-down pins, two flops each
    always_ff @(posedge aclk)
    begin
        pin_meta <= {power_down, link_power_sense};
        pin_sync <= pin_meta;
    end
    assign rst_int = !aresetn || pin_sync[1];
    always_ff @(posedge aclk)
    begin
        if (rst_int || pin_sync[0])
            low_count <= '0;
        else if (low_count <= DISABLE_COUNT)
            low_count <= low_count + CNT_W'(1);
    end
    always_comb
    begin
        if (low_count > DISABLE_COUNT)
            next_state = PS_DISABLED;
        else if (low_count > RESET_COUNT)
            next_state = PS_RESET;
        else
            next_state = PS_ACTIVE;
    end
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            state <= PS_ACTIVE;
            hold_low_a <= 1'b0;
            clk_stop_a <= 1'b0;
            run_a <= 1'b0;
        end
        else
        begin
            state <= next_state;
            run_a <= 1'b1;
            hold_low_a <= (next_state != PS_ACTIVE);
            clk_stop_a <= (next_state == PS_DISABLED);
        end
    end
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            self_id_link_active <= 1'b0;
            power_sense_active <= 1'b0;
        end
        else
        begin
            power_sense_active <= (state == PS_ACTIVE);
            self_id_link_active <= (state == PS_ACTIVE) && link_active_ctrl;
        end
    end
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_port
        assign next_cable[i] = port_off(port_status[i], port_ctrl[i]);
    end
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            cable_power_disable <= '0;
            all_ports_cable_power_disable <= 1'b0;
        end
        else
        begin
            cable_power_disable <= next_cable;
            all_ports_cable_power_disable <= &next_cable;
        end
    end
    // axi write path
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign strb_mask = lane_mask(wstrb_q);
    assign wr_mask = wdata_q & strb_mask;
    assign port_word = {{(32-NUM_PORTS*PORT_CTRL_W){1'b0}}, port_ctrl};
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (aw_held && w_held && !bvalid)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            link_active_ctrl <= 1'b0;
            port_ctrl <= '0;
        end
        else if (aw_held && w_held && !bvalid)
        begin
            if (awaddr_q == CONFIG_OFFSET && wstrb_q[0])
                link_active_ctrl <= wdata_q[CFG_LINK_ACTIVE_BIT];
            if (awaddr_q == PORT_CTRL_OFFSET)
                port_ctrl <= (port_word[NUM_PORTS*PORT_CTRL_W-1:0] &
                              ~strb_mask[NUM_PORTS*PORT_CTRL_W-1:0]) |
                             wr_mask[NUM_PORTS*PORT_CTRL_W-1:0];
        end
    end
    // axi read path
    assign arready = !rvalid;
    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            rvalid <= 1'b0;
            rdata <= ZERO_WORD;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata <= ZERO_WORD;
            case (araddr)
                CONFIG_OFFSET: rdata[CFG_LINK_ACTIVE_BIT] <= link_active_ctrl;
                PORT_CTRL_OFFSET: rdata <= port_word;
                STATUS_OFFSET:
                begin
                    rdata[ST_STATE_LSB +: 2] <= state;
                    rdata[ST_SENSE_BIT] <= power_sense_active;
                    rdata[ST_SELFID_BIT] <= self_id_link_active;
                end
                CABLE_OFFSET:
                begin
                    rdata[NUM_PORTS-1:0] <= cable_power_disable;
                    rdata[ALL_PORTS_BIT] <= all_ports_cable_power_disable;
                end
                default: rdata <= ZERO_WORD;
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end
    // link domain: reset, pins and state levels cross on two flops
    logic link_rst_meta;
    logic link_run;
    logic [3:0] link_meta;
    logic [3:0] link_sync;
    logic req_s;
    logic mode_fast;
    logic hold_low;
    logic clk_stop;
    logic div_phase;
    always_ff @(posedge link_clk)
    begin
        link_rst_meta <= run_a;
        link_run <= link_rst_meta;
        link_meta <= {clk_stop_a, hold_low_a, interface_mode_select, link_service_request};
        link_sync <= link_meta;
    end
    assign {clk_stop, hold_low, mode_fast, req_s} = link_sync;
    always_ff @(posedge link_clk)
    begin
        if (!link_run || hold_low)
        begin
            interface_control_lines <= 2'h0;
            link_data_out <= 8'h00;
            core_service_request <= 1'b0;
        end
        else
        begin
            interface_control_lines <= core_control;
            link_data_out <= core_data;
            core_service_request <= req_s;
        end
    end
    always_ff @(posedge link_clk)
    begin
        if (!link_run || clk_stop)
        begin
            interface_clock <= 1'b0;
            div_phase <= 1'b0;
        end
        else
        begin
            div_phase <= !div_phase;
            if (mode_fast || div_phase)
                interface_clock <= !interface_clock;
        end
    end
    chk_reset_entry: assert property (@(posedge aclk) disable iff (rst_int)
        low_count > RESET_COUNT |=> state != PS_ACTIVE)
        else $error("reset state not entered after long low");
    chk_active_on_high: assert property (@(posedge aclk) disable iff (rst_int)
        pin_sync[0] |-> ##2 state == PS_ACTIVE)
        else $error("sampled high did not keep interface active");
    chk_disable_entry: assert property (@(posedge aclk) disable iff (rst_int)
        low_count > DISABLE_COUNT |=> state == PS_DISABLED && clk_stop_a)
        else $error("disabled state not entered");
    chk_count_restart: assert property (@(posedge aclk) disable iff (rst_int)
        pin_sync[0] |=> low_count == '0)
        else $error("low counter did not restart");
    chk_selfid_off: assert property (@(posedge aclk) disable iff (rst_int)
        low_count > RESET_COUNT |-> ##2 !self_id_link_active)
        else $error("self-id shows link active while sense inactive");
    chk_all_ports: assert property (@(posedge aclk) disable iff (rst_int)
        all_ports_cable_power_disable == &cable_power_disable)
        else $error("all-ports flag differs from per-port AND");
    chk_cable_idle: assert property (@(posedge aclk) disable iff (rst_int)
        port_status[0].ds_connected && !port_status[0].active && !port_status[0].dc_connected
        |=> cable_power_disable[0])
        else $error("idle data-strobe port keeps cable power");
    chk_cable_enable: assert property (@(posedge aclk) disable iff (rst_int)
        port_status[1].active && !port_status[1].disconnected && !port_status[1].asleep
        && !port_ctrl[1].disabled |=> !cable_power_disable[1])
        else $error("active port has cable power disabled");
    chk_hard_disable: assert property (@(posedge aclk) disable iff (rst_int)
        port_ctrl[2].disabled && port_ctrl[2].hard_disable |=> cable_power_disable[2])
        else $error("hard-disabled port keeps cable power");
    chk_outputs_low: assert property (@(posedge link_clk) disable iff (!link_run)
        hold_low |=> interface_control_lines == 2'h0 && link_data_out == 8'h00
        && !core_service_request)
        else $error("interface outputs not held low");
    chk_clock_stop: assert property (@(posedge link_clk) disable iff (!link_run)
        clk_stop |=> !interface_clock)
        else $error("interface clock runs while disabled");
    chk_clock_fast: assert property (@(posedge link_clk) disable iff (!link_run)
        mode_fast && !clk_stop |=> interface_clock != $past(interface_clock))
        else $error("fast mode clock did not toggle");
    chk_clock_legacy: assert property (@(posedge link_clk) disable iff (!link_run)
        !mode_fast && !clk_stop && !div_phase |=> $stable(interface_clock))
        else $error("legacy clock toggled too fast");
    cov_reset_state: cover property (@(posedge aclk) disable iff (rst_int)
        state == PS_RESET);
    cov_disabled: cover property (@(posedge aclk) disable iff (rst_int)
        state == PS_DISABLED ##1 state == PS_ACTIVE);
    cov_write: cover property (@(posedge aclk) disable iff (rst_int)
        bvalid && bready && bresp == RESP_OKAY);
    cov_selfid: cover property (@(posedge aclk) disable iff (rst_int)
        $rose(self_id_link_active));
endmodule

// ### rtl/lpsm_pkg.sv
// Purpose: constants, types and register map of the link power status monitor
// Assumes: aclk at 100 MHz, AXI4-Lite with 32-bit data
// Notes:
// Contract
// - The power-sense input counts as inactive only after it has been sampled low for more than 2.6 us.
// - When power-sense turns inactive, the parallel interface enters its low-power reset state.
// - In the reset state control and data outputs are held at 0, requests are ignored, the clock runs.
// - After more than 26 us of low power-sense the interface is disabled and its clock stops.
// - Self-ID reports the link as active only when power-sense is active and the link-active bit is 1.
// - The interface clock runs at 98.304 MHz with mode select high and at 49.152 MHz with it low.
// - A port's cable-power disable is set when it is disconnected, asleep, or data-strobe but idle.
// - Otherwise, when the port is dc-connected or active, the cable-power disable is cleared.
// - A hard-disabled or sleep-disabled port also sets its cable-power disable.
// - Bit 6 of the cable register is the AND of the three per-port disable bits.
package lpsm_pkg;
    localparam int CLK_MHZ = 100;
    localparam real POWER_SENSE_RESET_US = 2.6;
    localparam real POWER_SENSE_DISABLE_US = 26.0;
    localparam real POWER_SENSE_MIN_HIGH_NS = 22.0;
    localparam int RESET_CYC = int'(POWER_SENSE_RESET_US * CLK_MHZ);
    localparam int DISABLE_CYC = int'(POWER_SENSE_DISABLE_US * CLK_MHZ);
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] RESET_COUNT = CNT_W'(RESET_CYC);
    localparam logic [CNT_W-1:0] DISABLE_COUNT = CNT_W'(DISABLE_CYC);
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] PORT_CTRL_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] CABLE_OFFSET = 8'h0C;
    localparam int CFG_LINK_ACTIVE_BIT = 0;
    localparam int PORT_CTRL_W = 3;
    localparam int ALL_PORTS_BIT = 6;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SENSE_BIT = 2;
    localparam int ST_SELFID_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {PS_ACTIVE, PS_RESET, PS_DISABLED} power_state_type;
    typedef struct packed {
        logic disconnected;
        logic asleep;
        logic ds_connected;
        logic active;
        logic dc_connected;
    } port_status_type;
    typedef struct packed {
        logic sleep_enable;
        logic hard_disable;
        logic disabled;
    } port_ctrl_type;
endpackage
